// *** include/blsth_pkg.sv ***
// Constants and carriers of the link-side configuration header upper half.
// Assumes one clock domain; setup and load inputs come from same-clock logic.
package blsth_pkg;

    // ==========================================================
    // Register offsets (byte addresses in configuration space)
    localparam logic [7:0] OFS_HDR_MISC   = 8'h0C;
    localparam logic [7:0] OFS_WIN0       = 8'h10;
    localparam logic [7:0] OFS_WIN1       = 8'h14;
    localparam logic [7:0] OFS_WIN2_LO    = 8'h18;
    localparam logic [7:0] OFS_WIN2_HI    = 8'h1C;
    localparam logic [7:0] OFS_WIN3_LO    = 8'h20;
    localparam logic [7:0] OFS_WIN3_HI    = 8'h24;
    localparam logic [7:0] OFS_SUBSYS     = 8'h2C;
    localparam logic [7:0] OFS_OPTROM     = 8'h30;
    localparam logic [7:0] OFS_CAP_HEAD   = 8'h34;
    localparam logic [7:0] OFS_LEGACY_IRQ = 8'h3C;

    // ==========================================================
    // Window sizes (log2 of bytes)
    localparam logic [4:0] WIN0_SIZE_LOG2   = 5'd17;
    localparam logic [4:0] WIN1_SIZE_LOG2   = 5'd8;
    localparam logic [4:0] MEMWIN_MIN_LOG2  = 5'd12;
    localparam logic [4:0] OPTROM_MIN_LOG2  = 5'd11;
    localparam logic [4:0] OPTROM_MAX_LOG2  = 5'd15;

    // ==========================================================
    // Encodings
    localparam logic [1:0] TYPE_MEM32       = 2'b00;
    localparam logic [1:0] TYPE_MEM64       = 2'b10;
    localparam logic [1:0] SEL_IO_WINDOW    = 2'b11;
    localparam logic [1:0] SEL_NONE         = 2'b00;
    localparam logic [1:0] SETUP01_DEFAULT  = SEL_IO_WINDOW;
    localparam logic [7:0] IRQ_PIN_NONE     = 8'h00;
    localparam logic [7:0] IRQ_PIN_FIRST    = 8'h01;

    // ==========================================================
    // Values after reset, and the option ROM image start
    localparam logic [15:0] SUBSYS_VENDOR_RESET = 16'h1A2B; // Arbitrary value
    localparam logic [15:0] SUBSYS_ID_RESET     = 16'h3C4D; // Arbitrary value
    localparam logic [7:0]  CAP_HEAD_RESET      = 8'h40;
    localparam logic [7:0]  IRQ_PIN_RESET       = IRQ_PIN_FIRST;
    localparam logic [7:0]  IRQ_LINE_RESET      = 8'h00;
    localparam logic [15:0] OPTROM_IMAGE_START  = 16'h8000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic       enable;
        logic [1:0] kind;
        logic       prefetch;
        logic [4:0] size_log2;
    } blsth_setup_s;

    typedef struct packed {
        logic        valid;
        logic [7:0]  offset;
        logic [31:0] data;
    } blsth_load_s;

    typedef struct packed {
        logic [14:0] win0_base;
        logic [23:0] win1_base;
        logic [19:0] win2_base;
        logic [31:0] win2_upper;
        logic [19:0] win3_base;
        logic [31:0] win3_upper;
        logic [15:0] ss_vendor;
        logic [15:0] ss_id;
        logic [20:0] rom_base;
        logic        rom_en;
        logic [7:0]  cap_head;
        logic [7:0]  irq_line;
        logic [7:0]  irq_pin;
        logic [31:0] rdata;
        logic        rvalid;
        logic [15:0] rom_addr;
        logic        rom_valid;
    } blsth_state_s;

endpackage

// *** src/blsth_header.sv ***
// Link-side configuration header, upper half: windows, ids, option ROM,
// capability head and legacy interrupt bytes.
// Assumes configuration requests, setup values and loads arrive on clk.
`timescale 1ns/1ps

module blsth_header
    import blsth_pkg::*;
(
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Configuration access from the link
    input  wire logic               cfg_rd,
    input  wire logic               cfg_wr,
    input  wire logic [7:0]         cfg_addr,
    input  wire logic [3:0]         cfg_be,
    input  wire logic [31:0]        cfg_wdata,
    output logic      [31:0]        cfg_rdata,
    output logic                    cfg_rvalid,
    // Window setup from the setup registers
    input  wire logic [1:0]         first_window_pair_type_select,
    input  wire blsth_setup_s       second_window_pair_setup,
    input  wire blsth_setup_s       third_window_pair_setup,
    input  wire logic [4:0]         optrom_size_log2,
    input  wire logic               internal_virtual_side_rom_en,
    // Serial configuration memory loads
    input  wire blsth_load_s        cfg_load,
    // Option ROM fetch toward the serial memory
    input  wire logic               rom_fetch_req,
    input  wire logic [14:0]        rom_fetch_offset,
    output logic      [15:0]        rom_mem_addr,
    output logic                    rom_mem_valid,
    // Window bases for the address decoder
    output logic      [31:0]        win0_base_out,
    output logic      [31:0]        rom_base_out
);

    // ==========================================================
    // State
    blsth_state_s state_reg;
    blsth_state_s state_next;

    // ==========================================================
    // Helpers

    // Size mask, never finer than the window minimum
    function automatic logic [31:0] size_mask(input logic [4:0] lg,
                                              input logic [4:0] lo);
        logic [4:0] s;
        s = (lg < lo) ? lo : lg;
        return 32'hFFFF_FFFF << s;
    endfunction

    // Byte-enable merge of a write into an old value
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // Reported memory type: reserved codes never show
    function automatic logic [1:0] mem_kind(input blsth_setup_s s);
        return s.kind[1] ? TYPE_MEM64 : TYPE_MEM32;
    endfunction

    // ==========================================================
    // Derived controls
    logic        io_on;
    logic        w2_on;
    logic        w3_on;
    logic        w2_64;
    logic        w3_64;
    logic        rom_link;
    logic [31:0] m0;
    logic [31:0] m1;
    logic [31:0] m2;
    logic [31:0] m3;
    logic [31:0] mr;
    logic [4:0]  rom_lg;

    // Window presence and sizes from setup
    assign io_on    = (first_window_pair_type_select == SEL_IO_WINDOW);
    assign w2_on    = second_window_pair_setup.enable;
    assign w3_on    = third_window_pair_setup.enable;
    // 64-bit taken from the type msb for the second pair, so 11b counts; the third pair needs exactly 10b
    assign w2_64    = w2_on && second_window_pair_setup.kind[1];
    assign w3_64    = w3_on && (third_window_pair_setup.kind == TYPE_MEM64);
    assign rom_link = !internal_virtual_side_rom_en;
    assign rom_lg   = (optrom_size_log2 > OPTROM_MAX_LOG2) ? OPTROM_MAX_LOG2
                                                           : optrom_size_log2;
    assign m0       = size_mask(WIN0_SIZE_LOG2, WIN0_SIZE_LOG2);
    assign m1       = size_mask(WIN1_SIZE_LOG2, WIN1_SIZE_LOG2);
    assign m2       = size_mask(second_window_pair_setup.size_log2,
                                MEMWIN_MIN_LOG2);
    assign m3       = size_mask(third_window_pair_setup.size_log2,
                                MEMWIN_MIN_LOG2);
    assign mr       = size_mask(rom_lg, OPTROM_MIN_LOG2);

    // ==========================================================
    // Register images as read by the link
    logic [31:0] img_win0;
    logic [31:0] img_win1;
    logic [31:0] img_win2;
    logic [31:0] img_win2h;
    logic [31:0] img_win3;
    logic [31:0] img_win3h;
    logic [31:0] img_rom;
    logic [31:0] rd_mux;

    // Fixed 32-bit non-prefetchable control window
    assign img_win0 = {state_reg.win0_base, 17'h0_0000} & m0;

    // I/O window, or all zero when not selected
    assign img_win1 = io_on ? (({state_reg.win1_base, 8'h00} & m1)
                               | 32'h0000_0001)
                            : 32'h0000_0000;

    // Second memory window; reserved low bits stay zero
    assign img_win2 = w2_on ? (({state_reg.win2_base, 12'h000} & m2)
                               | {28'h000_0000,
                                  second_window_pair_setup.prefetch,
                                  mem_kind(second_window_pair_setup),
                                  1'b0})
                            : 32'h0000_0000;
    assign img_win2h = w2_64 ? state_reg.win2_upper : 32'h0000_0000;

    // Third memory window
    assign img_win3 = w3_on ? (({state_reg.win3_base, 12'h000} & m3)
                               | {28'h000_0000,
                                  third_window_pair_setup.prefetch,
                                  mem_kind(third_window_pair_setup),
                                  1'b0})
                            : 32'h0000_0000;
    assign img_win3h = w3_64 ? state_reg.win3_upper : 32'h0000_0000;

    // Option ROM: base, zeros, enable; clear while the virtual side owns it
    assign img_rom = rom_link ? (({state_reg.rom_base, 11'h000} & mr)
                                 | {31'h0000_0000, state_reg.rom_en})
                              : 32'h0000_0000;

    // Read decode; unmapped offsets read zero
    always_comb begin
        case (cfg_addr)
            OFS_HDR_MISC:   rd_mux = 32'h0000_0000;
            OFS_WIN0:       rd_mux = img_win0;
            OFS_WIN1:       rd_mux = img_win1;
            OFS_WIN2_LO:    rd_mux = img_win2;
            OFS_WIN2_HI:    rd_mux = img_win2h;
            OFS_WIN3_LO:    rd_mux = img_win3;
            OFS_WIN3_HI:    rd_mux = img_win3h;
            OFS_SUBSYS:     rd_mux = {state_reg.ss_id, state_reg.ss_vendor};
            OFS_OPTROM:     rd_mux = img_rom;
            OFS_CAP_HEAD:   rd_mux = {24'h00_0000, state_reg.cap_head};
            OFS_LEGACY_IRQ: rd_mux = {16'h0000, state_reg.irq_pin,
                                      state_reg.irq_line};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================================
    // Next state
    logic [31:0] wv;

    // Loads first, then link writes; a write to a loaded field wins
    always_comb begin
        state_next = state_reg;
        wv         = 32'h0000_0000;

        // Hardware-initialized fields from serial memory
        if (cfg_load.valid) begin
            case (cfg_load.offset)
                OFS_SUBSYS: begin
                    state_next.ss_vendor = cfg_load.data[15:0];
                    state_next.ss_id     = cfg_load.data[31:16];
                end
                OFS_CAP_HEAD: begin
                    state_next.cap_head = cfg_load.data[7:0];
                end
                OFS_LEGACY_IRQ: begin
                    state_next.irq_line = cfg_load.data[7:0];
                    // Only no-interrupt or first legacy interrupt accepted
                    if (cfg_load.data[15:8] == IRQ_PIN_NONE ||
                        cfg_load.data[15:8] == IRQ_PIN_FIRST) begin
                        state_next.irq_pin = cfg_load.data[15:8];
                    end
                end
                default: begin
                    state_next = state_next;
                end
            endcase
        end

        // Link writes: only writable fields take data, masked to size
        if (cfg_wr) begin
            case (cfg_addr)
                OFS_WIN0: begin
                    wv = merge(img_win0, cfg_wdata, cfg_be) & m0;
                    state_next.win0_base = wv[31:17];
                end
                OFS_WIN1: begin
                    if (io_on) begin
                        wv = merge(img_win1, cfg_wdata, cfg_be) & m1;
                        state_next.win1_base = wv[31:8];
                    end
                end
                OFS_WIN2_LO: begin
                    if (w2_on) begin
                        wv = merge(img_win2, cfg_wdata, cfg_be) & m2;
                        state_next.win2_base = wv[31:12];
                    end
                end
                OFS_WIN2_HI: begin
                    if (w2_64) begin
                        state_next.win2_upper = merge(img_win2h, cfg_wdata,
                                                      cfg_be);
                    end
                end
                OFS_WIN3_LO: begin
                    if (w3_on) begin
                        wv = merge(img_win3, cfg_wdata, cfg_be) & m3;
                        state_next.win3_base = wv[31:12];
                    end
                end
                OFS_WIN3_HI: begin
                    if (w3_64) begin
                        state_next.win3_upper = merge(img_win3h, cfg_wdata,
                                                      cfg_be);
                    end
                end
                OFS_OPTROM: begin
                    if (rom_link) begin
                        wv = merge(img_rom, cfg_wdata, cfg_be);
                        state_next.rom_base = wv[31:11] & mr[31:11];
                        state_next.rom_en   = wv[0];
                    end
                end
                OFS_LEGACY_IRQ: begin
                    if (cfg_be[0]) begin
                        state_next.irq_line = cfg_wdata[7:0];
                    end
                end
                default: begin
                    state_next = state_next;
                end
            endcase
        end

        // Virtual side took the ROM: link copy cleared and held
        if (!rom_link) begin
            state_next.rom_base = 21'h00_0000;
            state_next.rom_en   = 1'b0;
        end

        // Read answer registered one cycle after the request
        state_next.rvalid = cfg_rd;
        state_next.rdata  = cfg_rd ? rd_mux : 32'h0000_0000;

        // ROM image sits in the upper half of the serial memory
        state_next.rom_valid = rom_fetch_req && rom_link && state_reg.rom_en;
        state_next.rom_addr  = OPTROM_IMAGE_START
                               | {1'b0, rom_fetch_offset & ~mr[14:0]};
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg            <= '0;
            state_reg.ss_vendor  <= SUBSYS_VENDOR_RESET;
            state_reg.ss_id      <= SUBSYS_ID_RESET;
            state_reg.cap_head   <= CAP_HEAD_RESET;
            state_reg.irq_pin    <= IRQ_PIN_RESET;
            state_reg.irq_line   <= IRQ_LINE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // Outputs, straight from the state flops
    assign cfg_rdata     = state_reg.rdata;
    assign cfg_rvalid    = state_reg.rvalid;
    assign rom_mem_addr  = state_reg.rom_addr;
    assign rom_mem_valid = state_reg.rom_valid;
    assign win0_base_out = {state_reg.win0_base, 17'h0_0000};
    assign rom_base_out  = {state_reg.rom_base, 11'h000};

endmodule

// *** tb/blsth_header_asserts.sv ***
// Checker for the link-side header upper half; sees only top-level ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps

module blsth_header_asserts
    import blsth_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Configuration access
    input  wire logic        cfg_rd,
    input  wire logic [7:0]  cfg_addr,
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid,
    // Setup and option ROM
    input  wire logic [1:0]  first_window_pair_type_select,
    input  wire logic        internal_virtual_side_rom_en,
    input  wire logic        rom_fetch_req,
    input  wire logic [15:0] rom_mem_addr,
    input  wire logic        rom_mem_valid
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==========================================================
    // Read request of one offset; its answer lands one edge later
    sequence s_rd(a);
        cfg_rd && cfg_addr == a;
    endsequence

    // Memory window low dword: flag, low type bit and reserved bits
    property p_mem_low(a);
        s_rd(a) |=> cfg_rdata[11:4] == 8'h00 && cfg_rdata[1:0] == 2'b00;
    endproperty

    // ==========================================================
    // Assertions
    chk_read_answer: assert property (cfg_rd |=> cfg_rvalid)
        else $error("read not answered");
    chk_idle_quiet: assert property (!cfg_rd |=> !cfg_rvalid && cfg_rdata == 32'h0000_0000)
        else $error("answer without read");
    chk_win0_low: assert property (s_rd(OFS_WIN0) |=> cfg_rdata[16:0] == 17'h0_0000)
        else $error("first window low bits set");
    chk_io_flag: assert property (s_rd(OFS_WIN1) |=> ($past(first_window_pair_type_select) == SEL_IO_WINDOW)
        ? cfg_rdata[7:0] == 8'h01 : cfg_rdata == 32'h0000_0000)
        else $error("io window flag wrong");
    chk_win2_low: assert property (p_mem_low(OFS_WIN2_LO))
        else $error("second window low bits wrong");
    chk_win3_low: assert property (p_mem_low(OFS_WIN3_LO))
        else $error("third window low bits wrong");
    chk_rom_low: assert property (s_rd(OFS_OPTROM) |=> cfg_rdata[10:1] == 10'h000)
        else $error("rom reserved bits set");
    chk_rom_owner: assert property (cfg_rd && cfg_addr == OFS_OPTROM && internal_virtual_side_rom_en
        |=> cfg_rdata == 32'h0000_0000)
        else $error("rom visible while owned elsewhere");
    chk_fetch_block: assert property (rom_fetch_req && internal_virtual_side_rom_en |=> !rom_mem_valid)
        else $error("fetch while owned elsewhere");
    chk_fetch_addr: assert property (rom_mem_valid |-> rom_mem_addr[15] && $past(rom_fetch_req))
        else $error("fetch address below image start");
    chk_cap_upper: assert property (s_rd(OFS_CAP_HEAD) |=> cfg_rdata[31:8] == 24'h00_0000)
        else $error("capability upper bits set");
    chk_hdr_misc: assert property (s_rd(OFS_HDR_MISC) |=> cfg_rdata[31:23] == 9'h000)
        else $error("header type or self test set");
    chk_irq_bytes: assert property (s_rd(OFS_LEGACY_IRQ) |=> cfg_rdata[31:9] == 23'h00_0000)
        else $error("interrupt upper bytes wrong");
endmodule

bind blsth_header blsth_header_asserts u_chk (
    .clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .cfg_rvalid(cfg_rvalid), .first_window_pair_type_select(first_window_pair_type_select),
    .internal_virtual_side_rom_en(internal_virtual_side_rom_en), .rom_fetch_req(rom_fetch_req),
    .rom_mem_addr(rom_mem_addr), .rom_mem_valid(rom_mem_valid)
);

// *** tb/blsth_host_model.sv ***
// Host configuration software model driving the header's access port.
// Assumes a single clock; requests launch 1 ns after the rising edge.
`timescale 1ns/1ps

module blsth_host
    import blsth_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Requests
    output logic             cfg_rd,
    output logic             cfg_wr,
    output logic [7:0]       cfg_addr,
    output logic [3:0]       cfg_be,
    output logic [31:0]      cfg_wdata,
    // Answer
    input  wire logic [31:0] cfg_rdata,
    input  wire logic        cfg_rvalid
);
    // Idle bus at time zero
    initial begin
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0000_0000;
    end

    // ==========================================================
    // One write; released lines flip so stale values never look live
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, a, be, d};
        @(posedge clk);
        #1;
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b0, ~a, ~be, ~d};
    endtask

    // One read; the answer is due exactly one edge after the request
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ok);
        @(posedge clk);
        #1;
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(posedge clk);
        #1;
        {cfg_rd, cfg_addr} = {1'b0, ~a};
        ok = cfg_rvalid;
        d = cfg_rdata;
    endtask

    // Option ROM sizing only with the two legal patterns, never past 32 KB
    task automatic size_rom(input logic biggest);
        wr(OFS_OPTROM, 4'hF, biggest ? 32'hFFFF_8001 : 32'hFFFF_F801);
    endtask
endmodule

// *** tb/test_bridge_link_side_type0_header.sv ***
// Self-checking bench for the link-side header upper half.
// Assumes the host model drives the access port; bench drives the rest.
`timescale 1ns/1ps

module test_bridge_link_side_type0_header
    import blsth_pkg::*;
;
    logic clk, rst_n, cfg_rd, cfg_wr, cfg_rvalid, vrom, freq, mvalid;
    logic [7:0] cfg_addr;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, cfg_rdata, w0, rb;
    logic [1:0] sel;
    logic [4:0] rom_sz;
    logic [14:0] foff;
    logic [15:0] maddr;
    blsth_setup_s s2, s3;
    blsth_load_s ld;
    int fails = 0;
    int cmp_count = 0;

    // ==========================================================
    // Design, host and clock
    blsth_header DUT (.clk(clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .first_window_pair_type_select(sel), .second_window_pair_setup(s2), .third_window_pair_setup(s3),
        .optrom_size_log2(rom_sz), .internal_virtual_side_rom_en(vrom), .cfg_load(ld), .rom_fetch_req(freq),
        .rom_fetch_offset(foff), .rom_mem_addr(maddr), .rom_mem_valid(mvalid), .win0_base_out(w0),
        .rom_base_out(rb));
    blsth_host host (.clk(clk), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // Shared tasks
    task automatic close_out();
        $display("mismatches %0d compares %0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        host.rd(a, d, ok);
        if (ok !== 1'b1) begin
            fails++;
            close_out();
        end else begin
            check(d, exp);
        end
    endtask
    // Serial memory load pulse; released fields flip
    task automatic load(input logic [7:0] o, input logic [31:0] d);
        @(posedge clk);
        #1 ld = '{1'b1, o, d};
        @(posedge clk);
        #1 ld = '{1'b0, ~o, ~d};
    endtask
    task automatic fetch(input logic [14:0] o, input logic hit, input logic [15:0] exp);
        @(posedge clk);
        #1 {freq, foff} = {1'b1, o};
        @(posedge clk);
        #1 {freq, foff} = {1'b0, ~o};
        check({31'h0000_0000, mvalid}, {31'h0000_0000, hit});
        if (hit) check({16'h0000, maddr}, {16'h0000, exp});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_defaults();
        host.wr(OFS_HDR_MISC, 4'hF, 32'hFFFF_FFFF);
        host.wr(OFS_SUBSYS, 4'hF, 32'hFFFF_FFFF);
        host.wr(OFS_CAP_HEAD, 4'hF, 32'hFFFF_FFFF);
        rdchk(OFS_HDR_MISC, 32'h0000_0000);
        rdchk(OFS_SUBSYS, {SUBSYS_ID_RESET, SUBSYS_VENDOR_RESET});
        rdchk(OFS_CAP_HEAD, {24'h00_0000, CAP_HEAD_RESET});
        rdchk(OFS_LEGACY_IRQ, {16'h0000, IRQ_PIN_RESET, IRQ_LINE_RESET});
        rdchk(OFS_WIN0, 32'h0000_0000);
        rdchk(OFS_WIN1, 32'h0000_0001);
        rdchk(OFS_WIN2_HI, 32'h0000_0000);
        rdchk(OFS_WIN3_HI, 32'h0000_0000);
        rdchk(8'h40, 32'h0000_0000);
    endtask
    task automatic t_win0_io();
        host.wr(OFS_WIN0, 4'hF, 32'hFFFF_FFFF);
        rdchk(OFS_WIN0, 32'hFFFE_0000);
        check(w0, 32'hFFFE_0000);
        host.wr(OFS_WIN1, 4'hF, 32'hFFFF_FFFF);
        rdchk(OFS_WIN1, 32'hFFFF_FF01);
        host.wr(OFS_WIN1, 4'h2, 32'h0000_0000);
        rdchk(OFS_WIN1, 32'hFFFF_0001);
        sel = SEL_NONE;
        host.wr(OFS_WIN1, 4'hF, 32'h1234_5600);
        rdchk(OFS_WIN1, 32'h0000_0000);
        sel = SETUP01_DEFAULT;
        rdchk(OFS_WIN1, 32'hFFFF_0001);
    endtask
    task automatic t_win2();
        s2 = '{1'b1, TYPE_MEM64, 1'b1, 5'h10};
        host.wr(OFS_WIN2_LO, 4'hF, 32'hFFFF_FFFF);
        host.wr(OFS_WIN2_HI, 4'hF, 32'hFFFF_FFFF);
        rdchk(OFS_WIN2_LO, 32'hFFFF_000C);
        rdchk(OFS_WIN2_HI, 32'hFFFF_FFFF);
        s2 = '{1'b1, 2'b01, 1'b0, 5'h10};
        rdchk(OFS_WIN2_LO, 32'hFFFF_0000);
        rdchk(OFS_WIN2_HI, 32'h0000_0000);
        s2 = '{1'b1, 2'b11, 1'b0, 5'h10};
        host.wr(OFS_WIN2_HI, 4'hF, 32'h0000_1234);
        rdchk(OFS_WIN2_HI, 32'h0000_1234);
    endtask
    task automatic t_win3();
        s3 = '{1'b1, TYPE_MEM64, 1'b0, MEMWIN_MIN_LOG2};
        host.wr(OFS_WIN3_LO, 4'hF, 32'hFFFF_FFFF);
        host.wr(OFS_WIN3_HI, 4'hF, 32'hFFFF_FFFF);
        rdchk(OFS_WIN3_LO, 32'hFFFF_F004);
        rdchk(OFS_WIN3_HI, 32'hFFFF_FFFF);
        s3 = '{1'b1, TYPE_MEM32, 1'b1, MEMWIN_MIN_LOG2};
        rdchk(OFS_WIN3_HI, 32'h0000_0000);
        rdchk(OFS_WIN3_LO, 32'hFFFF_F008);
        s3 = '{1'b0, TYPE_MEM32, 1'b1, MEMWIN_MIN_LOG2};
        rdchk(OFS_WIN3_LO, 32'h0000_0000);
        s3 = '{1'b1, 2'b11, 1'b0, MEMWIN_MIN_LOG2};
        host.wr(OFS_WIN3_HI, 4'hF, 32'h0000_1234);
        rdchk(OFS_WIN3_HI, 32'h0000_0000);
        rdchk(OFS_WIN3_LO, 32'hFFFF_F004);
    endtask
    task automatic t_rom();
        rom_sz = OPTROM_MAX_LOG2;
        host.size_rom(1'b1);
        rdchk(OFS_OPTROM, 32'hFFFF_8001);
        check(rb, 32'hFFFF_8000);
        fetch(15'h7FFF, 1'b1, 16'hFFFF);
        rom_sz = OPTROM_MIN_LOG2;
        host.size_rom(1'b0);
        rdchk(OFS_OPTROM, 32'hFFFF_F801);
        fetch(15'h0810, 1'b1, 16'h8010);
        host.wr(OFS_OPTROM, 4'hF, 32'hFFFF_F800);
        fetch(15'h0010, 1'b0, 16'h0000);
        vrom = 1'b1;
        host.wr(OFS_OPTROM, 4'hF, 32'hFFFF_F801);
        rdchk(OFS_OPTROM, 32'h0000_0000);
        check(rb, 32'h0000_0000);
        fetch(15'h0010, 1'b0, 16'h0000);
        vrom = 1'b0;
    endtask
    task automatic t_irq_load();
        host.wr(OFS_LEGACY_IRQ, 4'hF, 32'hFFFF_FFFF);
        rdchk(OFS_LEGACY_IRQ, 32'h0000_01FF);
        host.wr(OFS_LEGACY_IRQ, 4'h0, 32'h0000_0000);
        rdchk(OFS_LEGACY_IRQ, 32'h0000_01FF);
        load(OFS_LEGACY_IRQ, 32'h0000_02FF);
        rdchk(OFS_LEGACY_IRQ, 32'h0000_01FF);
        load(OFS_LEGACY_IRQ, 32'h0000_0033);
        rdchk(OFS_LEGACY_IRQ, 32'h0000_0033);
        load(OFS_SUBSYS, 32'h1234_5678);
        rdchk(OFS_SUBSYS, 32'h1234_5678);
        load(OFS_CAP_HEAD, 32'h0000_0050);
        rdchk(OFS_CAP_HEAD, 32'h0000_0050);
    endtask

    // ==========================================================
    // Main sequence: reset for 16 cycles, then every scenario
    initial begin
        {rst_n, vrom, freq, foff} = '0;
        sel = SETUP01_DEFAULT;
        s2 = '{1'b1, TYPE_MEM32, 1'b0, MEMWIN_MIN_LOG2};
        s3 = '{1'b1, TYPE_MEM32, 1'b0, MEMWIN_MIN_LOG2};
        rom_sz = OPTROM_MIN_LOG2;
        ld = '{1'b0, 8'h00, 32'h0000_0000};
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        t_defaults();
        t_win0_io();
        t_win2();
        t_win3();
        t_rom();
        t_irq_load();
        close_out();
    end
endmodule
